/* File: rtl/dxa_defs.svh */
// Constants for the extended-mode and activate link: offsets, fields, timing.
`ifndef DXA_DEFS_SVH
`define DXA_DEFS_SVH
// ----------------------------------------------------------------------
// Register offsets of the controller's APB slave.
// ----------------------------------------------------------------------
`define DXA_OFS_CMD    8'h00
`define DXA_OFS_ADDR   8'h04
`define DXA_OFS_STAT   8'h08
// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define DXA_E1_DLL     0
`define DXA_E1_HALF    1
`define DXA_E1_RTT0    2
`define DXA_E1_AL_LO   3
`define DXA_E1_AL_HI   5
`define DXA_E1_RTT1    6
`define DXA_E1_CAL_LO  7
`define DXA_E1_CAL_HI  9
`define DXA_E1_DQSN    10
`define DXA_E1_RO_STB  11
`define DXA_E2_HOT     7
`define DXA_A10        10
`define DXA_BA_MR      2'h0
`define DXA_BA_E1      2'h1
`define DXA_BA_E2      2'h2
`define DXA_BA_E3      2'h3
`define DXA_CMD_ODT    4
`define DXA_ADDR_BA    16
// ----------------------------------------------------------------------
// Timing: chosen times in ns, counts derived at the 40 ns clock; mode gap and DLL counts given directly in cycles.
// ----------------------------------------------------------------------
`define DXA_TCK_NS     40
`define DXA_T_RC_NS    55
`define DXA_T_RRD_NS   10
`define DXA_T_RP_NS    15
`define DXA_T_RCD_NS   15
`define DXA_T_FAW_NS   45
`define DXA_RU(ns)     (((ns) + `DXA_TCK_NS - 1) / `DXA_TCK_NS)
`define DXA_RC_CYC     `DXA_RU(`DXA_T_RC_NS)
`define DXA_RRD_CYC    `DXA_RU(`DXA_T_RRD_NS)
`define DXA_RP_CYC     `DXA_RU(`DXA_T_RP_NS)
`define DXA_RCD_CYC    `DXA_RU(`DXA_T_RCD_NS)
`define DXA_FAW_CYC    `DXA_RU(`DXA_T_FAW_NS)
`define DXA_MRD_CYC    2
`define DXA_DLL_CYC    200
`endif

/* File: rtl/dxa_pkg.sv */
// Types used by the controller end of the extended-mode and activate link.
package dxa_pkg;
	// Orders that software gives the controller.
	typedef enum logic [3:0] {
		DXA_OP_NOP, DXA_OP_CKE_ON, DXA_OP_MRS, DXA_OP_ACT, DXA_OP_RD,
		DXA_OP_WR, DXA_OP_PRE, DXA_OP_REF, DXA_OP_SRE, DXA_OP_SRX
	} dxa_op_t;
	// Eight-bit cycle counter used for every spacing check.
	typedef logic [7:0] dxa_cnt_t;
endpackage

/* File: rtl/dxa_if.sv */
// Command, address, termination and strobe pins between controller and memory.
interface dxa_if;
	logic        cke;      // Clock enable.
	logic        cs_n;     // Chip select, active low.
	logic        ras_n;    // Row strobe, active low.
	logic        cas_n;    // Column strobe, active low.
	logic        we_n;     // Write enable, active low.
	logic [2:0]  ba;       // Bank bits.
	logic [13:0] addr;     // Address lines.
	logic        odt;      // Termination control.
	logic        dm;       // Write mask from the controller.
	logic        ro_strobe;      // Read strobe driven by the memory.
	logic        ro_strobe_oe;   // Memory drives the shared mask/strobe pin.
	logic        ro_strobe_n_oe; // Memory drives the complementary read strobe.
	logic        dqsn_oe;        // Memory drives the complementary data strobe.
	modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm,
		input ro_strobe, ro_strobe_oe, ro_strobe_n_oe, dqsn_oe);
	modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm,
		output ro_strobe, ro_strobe_oe, ro_strobe_n_oe, dqsn_oe);
endinterface

/* File: rtl/dxa_mem.sv */
// Memory end: extended register decode, termination, strobe pins, posted column.
`include "dxa_defs.svh"
module dxa_mem #(
	parameter int CL    = 3, // Column latency, from the main mode register.
	parameter int BURST = 2  // Strobe cycles of one burst.
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	dxa_if.mem               bus,
	output      logic        dll_on,
	output      logic        drive_half,
	output      logic [2:0]  al,
	output      logic [2:0]  cal_mode,
	output      logic        hot_refresh,
	output      logic        self_ref,
	output      logic        odt_on,
	output      logic [1:0]  odt_sel,
	output      logic        wr_mask,
	output      logic        rd_go,
	output      logic        wr_go,
	output      logic [2:0]  go_bank,
	output      logic [13:0] act_row,
	output      logic [2:0]  act_bank,
	output      logic        act_go
);
	// Posted queue depth covers every value the 3-bit latency field holds.
	localparam int DEPTH = 8;
	// The strobe countdown is eight bits wide, so latency plus burst must fit it.
	if (CL < 1 || BURST < 1 || CL + BURST > 255) begin : g_bad_lat
		$error("dxa_mem: bad CL/BURST");
	end
	logic [13:0] ext1;           // Extended config 1 contents.
	logic [13:0] ext2;           // Extended config 2 contents.
	logic [13:0] ext3;           // Extended config 3, stored but without function.
	logic        cke_q;          // Clock enable seen at the previous edge.
	logic [4:0]  pend [DEPTH];   // Posted column slots: valid, write, bank.
	logic [7:0]  str_cnt;        // Read strobe countdown.
	logic        sel;            // A command is sampled this edge.
	logic        mrs, act, col, sre;
	logic        win;            // Read strobe window open.
	// ----------------------------------------------------------------------
	// Command decode.
	// ----------------------------------------------------------------------
	// Commands other than self refresh entry count only while awake and clock enable is high; select high is NOP.
	assign sel = bus.cke & cke_q & ~self_ref & ~bus.cs_n;
	assign mrs = sel & ~bus.ras_n & ~bus.cas_n & ~bus.we_n;
	assign act = sel & ~bus.ras_n & bus.cas_n & bus.we_n;
	assign col = sel & bus.ras_n & ~bus.cas_n;
	assign sre = cke_q & ~bus.cke & ~bus.cs_n & ~bus.ras_n & ~bus.cas_n & bus.we_n;
	assign win = (str_cnt != 8'h00) && (str_cnt <= 8'(BURST));
	// ----------------------------------------------------------------------
	// Extended registers.
	// ----------------------------------------------------------------------
	// Contents are undefined until written; reset clears them only for a tidy model.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ext1 <= 14'h0000;
			ext2 <= 14'h0000;
			ext3 <= 14'h0000;
		end else if (mrs && !bus.ba[2]) begin
			case (bus.ba[1:0])
				`DXA_BA_E1: ext1 <= bus.addr;
				`DXA_BA_E2: ext2 <= bus.addr;
				`DXA_BA_E3: ext3 <= bus.addr;
				default: ;
			endcase
		end
	end
	// ----------------------------------------------------------------------
	// Self refresh state.
	// ----------------------------------------------------------------------
	// Entry on refresh with clock enable falling; exit when clock enable returns.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cke_q    <= 1'b0;
			self_ref <= 1'b0;
		end else begin
			cke_q <= bus.cke;
			if (sre && !self_ref) begin
				self_ref <= 1'b1;
			end else if (self_ref && bus.cke) begin
				self_ref <= 1'b0;
			end
		end
	end
	// ----------------------------------------------------------------------
	// Decoded settings, registered so every output is a flop.
	// ----------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dll_on      <= 1'b0;
			drive_half  <= 1'b0;
			al          <= 3'h0;
			cal_mode    <= 3'h0;
			hot_refresh <= 1'b0;
			odt_on      <= 1'b0;
			odt_sel     <= 2'h0;
			wr_mask     <= 1'b0;
		end else begin
			// DLL follows the enable bit but drops while in self refresh.
			dll_on      <= ~ext1[`DXA_E1_DLL] & ~self_ref;
			drive_half  <= ext1[`DXA_E1_HALF];
			al          <= ext1[`DXA_E1_AL_HI:`DXA_E1_AL_LO];
			cal_mode    <= ext1[`DXA_E1_CAL_HI:`DXA_E1_CAL_LO];
			hot_refresh <= ext2[`DXA_E2_HOT];
			// Selection 00 means no resistor, so the pin alone cannot switch one in.
			odt_sel     <= {ext1[`DXA_E1_RTT1], ext1[`DXA_E1_RTT0]};
			odt_on      <= bus.odt & ~self_ref & (ext1[`DXA_E1_RTT1] | ext1[`DXA_E1_RTT0]);
			// The shared pin stops being a mask once read strobe is enabled.
			wr_mask     <= bus.dm & ~ext1[`DXA_E1_RO_STB];
		end
	end
	// ----------------------------------------------------------------------
	// Activate capture.
	// ----------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			act_go   <= 1'b0;
			act_bank <= 3'h0;
			act_row  <= 14'h0000;
		end else begin
			act_go <= act;
			if (act) begin
				act_bank <= bus.ba;
				act_row  <= bus.addr;
			end
		end
	end
	// ----------------------------------------------------------------------
	// Posted column queue.
	// ----------------------------------------------------------------------
	// A column command enters at the slot named by the additive latency and
	// walks down one slot per cycle, so it is issued internally AL cycles late.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				pend[i] <= 5'h00;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				if (col && i == int'(ext1[`DXA_E1_AL_HI:`DXA_E1_AL_LO])) begin
					pend[i] <= {1'b1, ~bus.we_n, bus.ba};
				end else if (i < DEPTH - 1) begin
					pend[i] <= pend[i + 1];
				end else begin
					pend[i] <= 5'h00;
				end
			end
		end
	end
	// ----------------------------------------------------------------------
	// Internal issue and read strobe.
	// ----------------------------------------------------------------------
	// Data of a read comes CL cycles after internal issue, hence RL = AL + CL.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rd_go   <= 1'b0;
			wr_go   <= 1'b0;
			go_bank <= 3'h0;
			str_cnt <= 8'h00;
		end else begin
			rd_go   <= pend[0][4] & ~pend[0][3];
			wr_go   <= pend[0][4] & pend[0][3];
			go_bank <= pend[0][2:0];
			if (pend[0][4] && !pend[0][3]) begin
				str_cnt <= 8'(CL + BURST);
			end else if (str_cnt != 8'h00) begin
				str_cnt <= str_cnt - 8'h01;
			end
		end
	end
	// Strobe pins follow A11 and A10; a disabled complement is left undriven.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bus.ro_strobe      <= 1'b0;
			bus.ro_strobe_oe   <= 1'b0;
			bus.ro_strobe_n_oe <= 1'b0;
			bus.dqsn_oe        <= 1'b0;
		end else begin
			bus.ro_strobe      <= win & ~bus.ro_strobe;
			bus.ro_strobe_oe   <= win & ext1[`DXA_E1_RO_STB];
			bus.ro_strobe_n_oe <= win & ext1[`DXA_E1_RO_STB] & ~ext1[`DXA_E1_DQSN];
			bus.dqsn_oe        <= win & ~ext1[`DXA_E1_DQSN];
		end
	end
endmodule // dxa_mem

/* File: rtl/dxa_ctl.sv */
// Controller end: APB orders, spacing checks and command pin driving.
`include "dxa_defs.svh"
module dxa_ctl #(
	parameter int FAW_SLOTS = 4 // Window slots; each activate loads every free slot, so one activate per window.
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	dxa_if.ctl               bus
);
	// Every wait is held in an eight-bit counter, so longer DLL and row cycle counts are refused.
	if (FAW_SLOTS < 1 || `DXA_DLL_CYC > 255 || `DXA_RC_CYC > 255) begin : g_bad_cnt
		$error("dxa_ctl: bad counts");
	end
	localparam dxa_pkg::dxa_cnt_t RC  = 8'(`DXA_RC_CYC);
	localparam dxa_pkg::dxa_cnt_t RRD = 8'(`DXA_RRD_CYC);
	localparam dxa_pkg::dxa_cnt_t RP  = 8'(`DXA_RP_CYC);
	localparam dxa_pkg::dxa_cnt_t RCD = 8'(`DXA_RCD_CYC);
	localparam dxa_pkg::dxa_cnt_t FAW = 8'(`DXA_FAW_CYC);
	localparam dxa_pkg::dxa_cnt_t MRD = 8'(`DXA_MRD_CYC);
	localparam dxa_pkg::dxa_cnt_t DLL = 8'(`DXA_DLL_CYC);
	dxa_pkg::dxa_op_t  op;                  // Pending order.
	logic [13:0]       addr_q;              // Pending address.
	logic [2:0]        ba_q;                // Pending bank bits.
	logic              go;                  // An order waits to be issued.
	logic              odt_q;               // Software termination request.
	logic              refused;             // Last order was illegal and dropped.
	logic [2:0]        al_q;                // Additive latency last programmed.
	logic [7:0]        open_b;              // Banks with an open row.
	dxa_pkg::dxa_cnt_t bk_cnt  [8];         // Per-bank row cycle or precharge wait.
	dxa_pkg::dxa_cnt_t rcd_cnt [8];         // Per-bank row-to-column wait.
	dxa_pkg::dxa_cnt_t faw_cnt [FAW_SLOTS]; // Open slots of the activate window.
	dxa_pkg::dxa_cnt_t rrd, mrd, dll;       // Global waits.
	logic              faw_free;            // Some window slot has expired.
	logic              ok, bad, fire, wr_acc;
	logic [13:0]       mrs_addr;            // Address with reserved bits forced.
	// ----------------------------------------------------------------------
	// Legality and readiness of the pending order.
	// ----------------------------------------------------------------------
	always_comb begin
		faw_free = 1'b0;
		for (int i = 0; i < FAW_SLOTS; i++) begin
			if (faw_cnt[i] == 8'h00) faw_free = 1'b1;
		end
		bad = 1'b0;
		ok  = (mrd == 8'h00);
		case (op)
			dxa_pkg::DXA_OP_MRS: begin
				bad = (open_b != 8'h00) || !bus.cke;
				for (int b = 0; b < 8; b++) begin
					if (bk_cnt[b] != 8'h00) ok = 1'b0;
				end
			end
			dxa_pkg::DXA_OP_ACT: begin
				bad = open_b[ba_q];
				ok  = ok && bk_cnt[ba_q] == 8'h00 && rrd == 8'h00 && faw_free;
			end
			dxa_pkg::DXA_OP_RD: begin
				bad = !open_b[ba_q];
				// A read waits for DLL lock and for AL to cover the row delay.
				ok  = ok && dll == 8'h00 && rcd_cnt[ba_q] <= 8'(al_q);
			end
			dxa_pkg::DXA_OP_WR: begin
				bad = !open_b[ba_q];
				ok  = ok && rcd_cnt[ba_q] <= 8'(al_q);
			end
			dxa_pkg::DXA_OP_REF, dxa_pkg::DXA_OP_SRE: begin
				bad = (open_b != 8'h00);
			end
			default: ;
		endcase
		fire = go && ok && !bad;
	end
	// Reserved bits are forced low so software cannot break the register layout.
	always_comb begin
		case (ba_q[1:0])
			`DXA_BA_E1: mrs_addr = {1'b0, addr_q[12:0]};
			`DXA_BA_E2: mrs_addr = addr_q & (14'h0001 << `DXA_E2_HOT);
			`DXA_BA_E3: mrs_addr = 14'h0000;
			default:    mrs_addr = addr_q;
		endcase
	end
	// ----------------------------------------------------------------------
	// APB slave: one wait-free answer, registered in the setup cycle.
	// ----------------------------------------------------------------------
	assign wr_acc = psel && penable && pready && pwrite;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && paddr != `DXA_OFS_CMD && paddr != `DXA_OFS_ADDR
				&& paddr != `DXA_OFS_STAT;
			case (paddr)
				`DXA_OFS_CMD:  prdata <= {27'h0, odt_q, op};
				`DXA_OFS_ADDR: prdata <= {13'h0, ba_q, 2'h0, addr_q};
				`DXA_OFS_STAT: prdata <= {16'h0, open_b, 2'h0, al_q, (dll == 8'h00), refused, go};
				default:       prdata <= 32'h0000_0000;
			endcase
		end
	end
	// ----------------------------------------------------------------------
	// Order register and issue sequencing.
	// ----------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			op      <= dxa_pkg::DXA_OP_NOP;
			addr_q  <= 14'h0000;
			ba_q    <= 3'h0;
			go      <= 1'b0;
			odt_q   <= 1'b0;
			refused <= 1'b0;
		end else begin
			// The termination request follows every command write, pending order or not.
			if (wr_acc && paddr == `DXA_OFS_CMD) begin
				odt_q <= pwdata[`DXA_CMD_ODT];
			end
			// A register write must never hide an issue: a fired order retires in the
			// same cycle, or the pins would repeat it.
			if (wr_acc && paddr == `DXA_OFS_ADDR && !go) begin
				addr_q <= pwdata[13:0];
				ba_q   <= pwdata[`DXA_ADDR_BA +: 3];
			end else if (wr_acc && paddr == `DXA_OFS_CMD && !go) begin
				// A new order is taken only when none is pending.
				op      <= dxa_pkg::dxa_op_t'(pwdata[3:0]);
				go      <= (pwdata[3:0] != 4'h0);
				refused <= 1'b0;
			end else if (go && bad) begin
				go      <= 1'b0;
				refused <= 1'b1;
			end else if (fire) begin
				// Calibration default is followed by calibration exit as soon as the mode gap has passed.
				if (op == dxa_pkg::DXA_OP_MRS && ba_q[1:0] == `DXA_BA_E1
					&& addr_q[`DXA_E1_CAL_HI:`DXA_E1_CAL_LO] == 3'h7) begin
					addr_q[`DXA_E1_CAL_HI:`DXA_E1_CAL_LO] <= 3'h0;
				end else begin
					go <= 1'b0;
				end
			end
		end
	end
	// ----------------------------------------------------------------------
	// Command pins: one command cycle per fired order except clock-enable on, self-refresh exit and unknown codes; deselect otherwise.
	// ----------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bus.cke   <= 1'b0;
			bus.cs_n  <= 1'b1;
			{bus.ras_n, bus.cas_n, bus.we_n} <= 3'h7;
			bus.ba    <= 3'h0;
			bus.addr  <= 14'h0000;
			bus.odt   <= 1'b0;
			bus.dm    <= 1'b0;
		end else begin
			bus.odt  <= odt_q;
			bus.cs_n <= !fire;
			bus.ba   <= ba_q;
			bus.addr <= addr_q;
			{bus.ras_n, bus.cas_n, bus.we_n} <= 3'h7;
			if (fire) begin
				case (op)
					dxa_pkg::DXA_OP_CKE_ON, dxa_pkg::DXA_OP_SRX: begin
						bus.cke  <= 1'b1;
						bus.cs_n <= 1'b1;
					end
					dxa_pkg::DXA_OP_MRS: begin
						{bus.ras_n, bus.cas_n, bus.we_n} <= 3'h0;
						bus.ba   <= {1'b0, ba_q[1:0]};
						bus.addr <= mrs_addr;
					end
					dxa_pkg::DXA_OP_ACT: {bus.ras_n, bus.cas_n, bus.we_n} <= 3'h3;
					dxa_pkg::DXA_OP_RD:  {bus.ras_n, bus.cas_n, bus.we_n} <= 3'h5;
					dxa_pkg::DXA_OP_WR:  {bus.ras_n, bus.cas_n, bus.we_n} <= 3'h4;
					dxa_pkg::DXA_OP_PRE: {bus.ras_n, bus.cas_n, bus.we_n} <= 3'h2;
					dxa_pkg::DXA_OP_REF: {bus.ras_n, bus.cas_n, bus.we_n} <= 3'h1;
					dxa_pkg::DXA_OP_SRE: begin
						{bus.ras_n, bus.cas_n, bus.we_n} <= 3'h1;
						bus.cke <= 1'b0;
					end
					default: bus.cs_n <= 1'b1;
				endcase
			end
		end
	end
	// ----------------------------------------------------------------------
	// Bank state and spacing counters.
	// ----------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			open_b <= 8'h00;
			al_q   <= 3'h0;
			rrd    <= 8'h00;
			mrd    <= 8'h00;
			dll    <= 8'h00;
			for (int b = 0; b < 8; b++) begin
				bk_cnt[b]  <= 8'h00;
				rcd_cnt[b] <= 8'h00;
			end
			for (int i = 0; i < FAW_SLOTS; i++) begin
				faw_cnt[i] <= 8'h00;
			end
		end else begin
			rrd <= (rrd != 8'h00) ? rrd - 8'h01 : 8'h00;
			mrd <= (mrd != 8'h00) ? mrd - 8'h01 : 8'h00;
			dll <= (dll != 8'h00) ? dll - 8'h01 : 8'h00;
			for (int b = 0; b < 8; b++) begin
				bk_cnt[b]  <= (bk_cnt[b] != 8'h00) ? bk_cnt[b] - 8'h01 : 8'h00;
				rcd_cnt[b] <= (rcd_cnt[b] != 8'h00) ? rcd_cnt[b] - 8'h01 : 8'h00;
			end
			for (int i = 0; i < FAW_SLOTS; i++) begin
				faw_cnt[i] <= (faw_cnt[i] != 8'h00) ? faw_cnt[i] - 8'h01 : 8'h00;
			end
			if (fire) begin
				case (op)
					dxa_pkg::DXA_OP_MRS: begin
						mrd <= MRD - 8'h01;
						if (ba_q[1:0] == `DXA_BA_E1) begin
							al_q <= addr_q[`DXA_E1_AL_HI:`DXA_E1_AL_LO];
							if (!addr_q[`DXA_E1_DLL]) dll <= DLL;
						end else if (ba_q[1:0] == `DXA_BA_MR) begin
							dll <= DLL;
						end
					end
					dxa_pkg::DXA_OP_SRX: dll <= DLL;
					dxa_pkg::DXA_OP_ACT: begin
						open_b[ba_q]  <= 1'b1;
						bk_cnt[ba_q]  <= RC - 8'h01;
						rcd_cnt[ba_q] <= RCD;
						rrd           <= RRD - 8'h01;
						for (int i = FAW_SLOTS - 1; i >= 0; i--) begin
							if (faw_cnt[i] == 8'h00) faw_cnt[i] <= FAW - 8'h01;
						end
					end
					dxa_pkg::DXA_OP_PRE: begin
						if (addr_q[`DXA_A10]) begin
							open_b <= 8'h00;
							for (int b = 0; b < 8; b++) begin
								if (bk_cnt[b] <= RP) bk_cnt[b] <= RP;
							end
						end else begin
							open_b[ba_q] <= 1'b0;
							if (bk_cnt[ba_q] < RP) bk_cnt[ba_q] <= RP - 8'h01;
						end
					end
					default: ;
				endcase
			end
		end
	end
endmodule // dxa_ctl

/* File: dv/dxa_monitor.sv */
// Checker on the command pins between the controller and the memory end.
module dxa_monitor (
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic        cke,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [2:0]  ba,
	input wire logic [13:0] addr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       mrs, act, rd; // Decoded commands on the pins.
	logic [7:0] lock;         // Cycles since the DLL last restarted.
	assign mrs = !cs_n && !ras_n && !cas_n && !we_n;
	assign act = !cs_n && !ras_n && cas_n && we_n;
	assign rd = !cs_n && ras_n && !cas_n && we_n;
	// Saturating count, so a long idle spell never wraps into a false early-read failure.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) lock <= 8'h00;
		else if (mrs && (ba[1:0] == 2'h0 || (ba[1:0] == 2'h1 && !addr[0]))) lock <= 8'h00;
		else if (lock != 8'hFF) lock <= lock + 8'h01;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	e1_reserved_a: assert property (mrs && ba[1:0] == 2'h1 |-> !addr[13] && !ba[2]) else $error("e1 reserved");
	e2_zero_a: assert property (mrs && ba[1:0] == 2'h2 |-> (addr & 14'h3F7F) == 14'h0) else $error("e2 bits");
	e3_zero_a: assert property (mrs && ba[1:0] == 2'h3 |-> addr == 14'h0 && !ba[2]) else $error("e3 bits");
	cal_exit_a: assert property (mrs && ba[1:0] == 2'h1 && addr[9:7] == 3'h7 |-> ##[2:8]
		(mrs && ba[1:0] == 2'h1 && addr[9:7] == 3'h0)) else $error("no cal exit");
	mrd_gap_a: assert property (mrs |=> cs_n) else $error("mode gap");
	mrs_cke_a: assert property (mrs |-> cke && $past(cke)) else $error("mode cke");
	pall_wait_a: assert property (!cs_n && !ras_n && cas_n && !we_n && addr[10] |=> !act) else $error("pall");
	dll_lock_a: assert property (rd |-> lock >= 8'hC7) else $error("early read");
endmodule // dxa_monitor

/* File: dv/ddr2_extended_mode_and_activate_tb.sv */
// Bench joining both ends: APB orders in, memory settings checked out.
module ddr2_extended_mode_and_activate_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, v;
	logic dll_on, drive_half, hot_refresh, odt_on, rd_go, wr_go, act_go, self_ref, err;
	logic [2:0] al, cal_mode, act_bank, go_bank;
	logic [1:0] odt_sel;
	logic [13:0] act_row, e;
	int failures = 0, total_checks = 0, seed = 53419, n;
	dxa_if bus_if();
	dxa_ctl dxa_ctl_i (.ref_clk(ref_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if));
	dxa_mem dxa_mem_i (.ref_clk(ref_clk), .nrst(nrst), .bus(bus_if), .dll_on(dll_on), .drive_half(drive_half),
		.al(al), .cal_mode(cal_mode), .hot_refresh(hot_refresh), .self_ref(self_ref), .odt_on(odt_on),
		.odt_sel(odt_sel), .wr_mask(), .rd_go(rd_go), .wr_go(wr_go), .go_bank(go_bank), .act_row(act_row),
		.act_bank(act_bank), .act_go(act_go));
	dxa_monitor dxa_monitor_i (.ref_clk, .nrst, .cke(bus_if.cke), .cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n),
		.cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .ba(bus_if.ba), .addr(bus_if.addr));
	initial forever #20 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One APB transfer; request held until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge ref_clk) penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
		@(posedge ref_clk);
	endtask
	// Load the address, give the order, then poll status until it leaves.
	task automatic op(input logic [3:0] o, input logic [31:0] a);
		apb(1, 8'h04, a);
		apb(1, 8'h00, {28'h0, o});
		do apb(0, 8'h08, 32'h0); while (rd[0] !== 1'b0);
	endtask
	// Column order to the active bank; n counts edges from the pins to internal issue.
	task automatic col(input logic [3:0] o);
		apb(1, 8'h04, {13'h0, v[18:16], 16'h0});
		apb(1, 8'h00, {28'h0, o});
		repeat (400) begin
			@(posedge ref_clk);
			if (!bus_if.cs_n && bus_if.ras_n && !bus_if.cas_n) break;
		end
		n = 0;
		repeat (9) begin
			@(posedge ref_clk);
			n++;
			if (rd_go === 1'b1 || wr_go === 1'b1) break;
		end
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		final_report;
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		nrst <= 1;
		v = $random(seed);
		op(4'h1, 32'h0);
		op(4'h6, 32'h400);
		op(4'h2, 32'h20000 | v[13:0]);
		chk(hot_refresh, v[7]);
		op(4'h2, 32'h30000 | v[13:0]);
		// Calibration default with AL 2 on extended config 1; the exit write follows by itself.
		e = (v[13:0] & 14'h0C46) | 14'h0390;
		op(4'h2, 32'h10000 | e);
		repeat (8) @(posedge ref_clk);
		chk({dll_on, drive_half, al, cal_mode}, {1'b1, e[1], 3'h2, 3'h0});
		chk(odt_sel, {e[6], e[2]});
		op(4'h3, {13'h0, v[18:16], 2'h0, v[29:16]});
		chk({act_bank, act_row}, {v[18:16], v[29:16]});
		op(4'h3, {13'h0, v[18:16], 16'h0});
		chk(rd[1], 1'b1);
		op(4'h2, 32'h10000);
		chk(rd[1], 1'b1);
		apb(1, 8'h00, 32'h10);
		repeat (3) @(posedge ref_clk);
		chk(odt_on, |{e[6], e[2]});
		// The read waits out the lock; issue shows AL + 2 edges after the pins.
		col(4'h4);
		chk(n, 4);
		chk({rd_go, wr_go, go_bank}, {2'b10, v[18:16]});
		repeat (4) @(posedge ref_clk);
		chk({bus_if.ro_strobe_oe, bus_if.ro_strobe_n_oe, bus_if.dqsn_oe}, {e[11], e[11] & ~e[10], ~e[10]});
		col(4'h5);
		chk(n, 4);
		chk({rd_go, wr_go, go_bank}, {2'b01, v[18:16]});
		op(4'h6, 32'h400);
		op(4'h8, 32'h0);
		apb(1, 8'h00, 32'h10);
		repeat (3) @(posedge ref_clk);
		chk({self_ref, dll_on, odt_on}, 3'h4);
		apb(1, 8'h00, 32'h19);
		repeat (3) @(posedge ref_clk);
		chk({self_ref, dll_on, odt_on}, {2'b01, |{e[6], e[2]}});
		apb(0, 8'h0C, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		final_report;
	end
endmodule // ddr2_extended_mode_and_activate_tb
